// >>> wdr_pkg.sv
package wdr_pkg;

   // ==========================================================
   // register map
   localparam logic [7:0] KEY_ADDR  = 8'ha6;
   localparam logic [7:0] CTRL_ADDR = 8'ha7;

   // ==========================================================
   // control register layout and value after reset
   localparam int         RUN_BIT    = 0;
   localparam int         OVF_BIT    = 1;
   localparam int         SWR_BIT    = 2;
   localparam int         IDLE_BIT   = 4;
   localparam int         PS_LSB     = 5;
   localparam int         PS_MSB     = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ==========================================================
   // key values
   localparam logic [7:0] KEY_RUN1  = 8'h1e;
   localparam logic [7:0] KEY_RUN2  = 8'he1;
   localparam logic [7:0] KEY_SOFT1 = 8'h5a;
   localparam logic [7:0] KEY_SOFT2 = 8'ha5;

   // ==========================================================
   // counting chain
   localparam int PRE_W   = 7;
   localparam int TMR_W   = 14;
   localparam int TPS_W   = 4;
   localparam int PS_BASE = 14;

   // ==========================================================
   // key sequence states
   typedef enum logic [1:0] {
      KEY_IDLE  = 2'b00,
      KEY_GOT_RUN  = 2'b01,
      KEY_GOT_SOFT = 2'b10
   } wdr_key_state_t;

endpackage

// >>> wdr_keyseq.sv
module wdr_keyseq (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       clear,
   input  wire logic       key_wr,
   input  wire logic [7:0] key_data,
   input  wire logic       other_wr,
   output logic            run_ok,
   output logic            soft_ok,
   output logic            bad_key
);

   // ==========================================================
   // key sequence tracking
   wdr_pkg::wdr_key_state_t state;
   wdr_pkg::wdr_key_state_t next_state;

   always_comb begin
      next_state = state;
      run_ok     = 1'b0;
      soft_ok    = 1'b0;
      bad_key    = 1'b0;
      case (state)
         wdr_pkg::KEY_IDLE: begin
            if (key_wr) begin
               if (key_data == wdr_pkg::KEY_RUN1) begin
                  next_state = wdr_pkg::KEY_GOT_RUN;
               end else if (key_data == wdr_pkg::KEY_SOFT1) begin
                  next_state = wdr_pkg::KEY_GOT_SOFT;
               end else begin
                  bad_key = 1'b1;
               end
            end
         end
         wdr_pkg::KEY_GOT_RUN: begin
            // reads in between are harmless; any other write breaks the pair
            if (other_wr) begin
               bad_key    = 1'b1;
               next_state = wdr_pkg::KEY_IDLE;
            end else if (key_wr) begin
               next_state = wdr_pkg::KEY_IDLE;
               run_ok     = (key_data == wdr_pkg::KEY_RUN2);
               bad_key    = (key_data != wdr_pkg::KEY_RUN2);
            end
         end
         wdr_pkg::KEY_GOT_SOFT: begin
            if (other_wr) begin
               bad_key    = 1'b1;
               next_state = wdr_pkg::KEY_IDLE;
            end else if (key_wr) begin
               next_state = wdr_pkg::KEY_IDLE;
               soft_ok    = (key_data == wdr_pkg::KEY_SOFT2);
               bad_key    = (key_data != wdr_pkg::KEY_SOFT2);
            end
         end
         default: begin
            next_state = wdr_pkg::KEY_IDLE;
         end
      endcase
      if (clear) begin
         next_state = wdr_pkg::KEY_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= wdr_pkg::KEY_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // checks
   a_pair_broken: assert property (@(posedge core_clk) disable iff (rst)
      (state != wdr_pkg::KEY_IDLE && other_wr && !clear) |-> bad_key)
      else $error("write between key bytes did not flag a bad key");

endmodule

// >>> wdr_watchdog.sv
module wdr_watchdog #(
   parameter int TPS_W = wdr_pkg::TPS_W
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             cpu_reset,
   input  wire logic [7:0]       sfr_addr,
   input  wire logic             sfr_wr,
   input  wire logic [7:0]       sfr_wdata,
   input  wire logic             sfr_rd,
   output logic      [7:0]       sfr_rdata,
   input  wire logic             idle,
   input  wire logic             power_down,
   input  wire logic [TPS_W-1:0] system_timer_prescale,
   output logic                  wdt_reset
);

   localparam int PRE_W = wdr_pkg::PRE_W;
   localparam int TMR_W = wdr_pkg::TMR_W;

   // ==========================================================
   // bus decode
   logic key_wr;
   logic ctrl_wr;
   logic other_wr;
   logic run_ok;
   logic soft_ok;
   logic bad_key;

   assign key_wr   = sfr_wr && (sfr_addr == wdr_pkg::KEY_ADDR);
   assign ctrl_wr  = sfr_wr && (sfr_addr == wdr_pkg::CTRL_ADDR);
   // a control write also counts: it is a register write between key bytes
   assign other_wr = sfr_wr && (sfr_addr != wdr_pkg::KEY_ADDR);

   wdr_keyseq u_keyseq (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (cpu_reset),
      .key_wr   (key_wr),
      .key_data (sfr_wdata),
      .other_wr (other_wr),
      .run_ok   (run_ok),
      .soft_ok  (soft_ok),
      .bad_key  (bad_key)
   );

   // ==========================================================
   // control register
   logic [2:0] period_select;
   logic       idle_freeze;
   logic       soft_reset_flag;
   logic       overflow_reset_flag;
   logic       running_flag;
   logic [2:0] next_period_select;
   logic       next_idle_freeze;
   logic       next_soft_reset_flag;
   logic       next_overflow_reset_flag;
   logic       next_running_flag;
   logic       timeout;
   logic       fire;

   // any reset request from this block, taken the same cycle it is seen
   assign fire = timeout || soft_ok || bad_key;

   always_comb begin
      next_period_select       = period_select;
      next_idle_freeze         = idle_freeze;
      next_soft_reset_flag     = soft_reset_flag;
      next_overflow_reset_flag = overflow_reset_flag;
      next_running_flag        = running_flag;
      if (ctrl_wr) begin
         next_period_select = sfr_wdata[wdr_pkg::PS_MSB:wdr_pkg::PS_LSB];
         next_idle_freeze   = sfr_wdata[wdr_pkg::IDLE_BIT];
         // flags clear on a written zero; a written one leaves them alone
         if (!sfr_wdata[wdr_pkg::SWR_BIT]) begin
            next_soft_reset_flag = 1'b0;
         end
         if (!sfr_wdata[wdr_pkg::OVF_BIT]) begin
            next_overflow_reset_flag = 1'b0;
         end
      end
      // flag sets win over a written clear in the same cycle; a stop wins over a start
      if (soft_ok || bad_key) begin
         next_soft_reset_flag = 1'b1;
      end
      if (timeout || bad_key) begin
         next_overflow_reset_flag = 1'b1;
      end
      if (run_ok) begin
         next_running_flag = 1'b1;
      end
      if (fire || cpu_reset) begin
         next_running_flag = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         period_select       <= wdr_pkg::CTRL_RESET[wdr_pkg::PS_MSB:wdr_pkg::PS_LSB];
         idle_freeze         <= wdr_pkg::CTRL_RESET[wdr_pkg::IDLE_BIT];
         soft_reset_flag     <= wdr_pkg::CTRL_RESET[wdr_pkg::SWR_BIT];
         overflow_reset_flag <= wdr_pkg::CTRL_RESET[wdr_pkg::OVF_BIT];
         running_flag        <= wdr_pkg::CTRL_RESET[wdr_pkg::RUN_BIT];
      end else begin
         period_select       <= next_period_select;
         idle_freeze         <= next_idle_freeze;
         soft_reset_flag     <= next_soft_reset_flag;
         overflow_reset_flag <= next_overflow_reset_flag;
         running_flag        <= next_running_flag;
      end
   end

   // ==========================================================
   // counting chain
   logic [TPS_W-1:0] tps_cnt;
   logic [PRE_W-1:0] pre_cnt;
   logic [TMR_W-1:0] tmr_cnt;
   logic [TPS_W-1:0] next_tps_cnt;
   logic [PRE_W-1:0] next_pre_cnt;
   logic [TMR_W-1:0] next_tmr_cnt;
   logic [PRE_W:0]   pre_span;
   logic [PRE_W-1:0] pre_max;
   logic             count_en;
   logic             tick;

   assign count_en = running_flag && !power_down && !(idle && idle_freeze);
   assign tick     = count_en && (tps_cnt == system_timer_prescale);
   // prescaler divides by two to the period code, timer divides by a further 2^14
   assign pre_span = (PRE_W + 1)'(1) << period_select;
   assign pre_max  = PRE_W'(pre_span - (PRE_W + 1)'(1));
   assign timeout  = tick && (pre_cnt == pre_max) && (&tmr_cnt);

   always_comb begin
      next_tps_cnt = tps_cnt;
      next_pre_cnt = pre_cnt;
      next_tmr_cnt = tmr_cnt;
      if (count_en) begin
         if (tick) begin
            next_tps_cnt = '0;
            if (pre_cnt >= pre_max) begin
               next_pre_cnt = '0;
               next_tmr_cnt = tmr_cnt + TMR_W'(1);
            end else begin
               next_pre_cnt = pre_cnt + PRE_W'(1);
            end
         end else begin
            next_tps_cnt = tps_cnt + TPS_W'(1);
         end
      end
      // a feed restarts the whole chain; so does every reset source
      if (run_ok || fire || cpu_reset) begin
         next_tps_cnt = '0;
         next_pre_cnt = '0;
         next_tmr_cnt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tps_cnt <= '0;
         pre_cnt <= '0;
         tmr_cnt <= '0;
      end else begin
         tps_cnt <= next_tps_cnt;
         pre_cnt <= next_pre_cnt;
         tmr_cnt <= next_tmr_cnt;
      end
   end

   // ==========================================================
   // reset request and read data
   logic       next_wdt_reset;
   logic [7:0] next_sfr_rdata;

   always_comb begin
      next_wdt_reset = fire;
      next_sfr_rdata = 8'h00;
      // key register is write-only and reads as zero, like unmapped space
      if (sfr_rd && (sfr_addr == wdr_pkg::CTRL_ADDR)) begin
         next_sfr_rdata = {period_select, idle_freeze, 1'b0, soft_reset_flag,
                           overflow_reset_flag, running_flag};
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wdt_reset <= 1'b0;
         sfr_rdata <= 8'h00;
      end else begin
         wdt_reset <= next_wdt_reset;
         sfr_rdata <= next_sfr_rdata;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   a_feed_restart: assert property (
      (run_ok && !cpu_reset) |=> (tmr_cnt == '0) && (pre_cnt == '0) && running_flag)
      else $error("feed did not restart the chain");

   a_start_running: assert property (
      (run_ok && !cpu_reset) |=> running_flag ##1
         (running_flag || $past(fire) || $past(cpu_reset)))
      else $error("enable key did not start the watchdog");

   a_timeout_reset: assert property (
      timeout |=> wdt_reset && overflow_reset_flag && !running_flag)
      else $error("time-out did not issue reset with overflow flag");

   a_bad_key_flags: assert property (
      bad_key |=> wdt_reset && soft_reset_flag && overflow_reset_flag)
      else $error("bad key did not reset with both flags");

   a_soft_reset_flag: assert property (
      (soft_ok && !bad_key) |=> wdt_reset && soft_reset_flag ##1 soft_reset_flag)
      else $error("software reset flag not set or not held");

   a_reset_pulse: assert property (
      (wdt_reset && !fire) |=> !wdt_reset)
      else $error("reset pulse wider than requested");

   a_freeze_idle: assert property (
      (idle && idle_freeze && !run_ok && !fire && !cpu_reset) |=>
         $stable(tmr_cnt) && $stable(pre_cnt))
      else $error("counter moved while frozen in idle");

   a_power_down: assert property (
      (power_down && !run_ok && !fire && !cpu_reset) |=> $stable(tmr_cnt))
      else $error("counter moved in power-down");

   a_reset_stops: assert property (
      cpu_reset |=> !running_flag)
      else $error("reset did not stop the watchdog");

   a_prescale_gap: assert property (
      (count_en && !tick && !run_ok && !fire && !cpu_reset) |=> $stable(pre_cnt))
      else $error("prescaler advanced without a tick");

   a_status_read: assert property (
      (sfr_rd && sfr_addr == wdr_pkg::CTRL_ADDR) |=>
         sfr_rdata[wdr_pkg::RUN_BIT] == $past(running_flag) && !sfr_rdata[3])
      else $error("status read does not match running flag");

   c_feed:     cover property (running_flag && run_ok);
   c_timeout:  cover property (timeout);
   c_bad_key:  cover property (bad_key);
   c_soft_rst: cover property (soft_ok);

endmodule

// >>> tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct {
      bit         is_rst;
      logic [7:0] val;
      int         at;
      int         slack;
   } wdr_note_t;

   logic                      core_clk              = 1'b0;
   logic                      rst                   = 1'b1;
   logic [7:0]                sfr_addr              = 8'h00;
   logic                      sfr_wr                = 1'b0;
   logic [7:0]                sfr_wdata             = 8'h00;
   logic                      sfr_rd                = 1'b0;
   logic [7:0]                sfr_rdata;
   logic                      idle                  = 1'b0;
   logic                      power_down            = 1'b0;
   logic [wdr_pkg::TPS_W-1:0] system_timer_prescale = '0;
   logic                      wdt_reset;
   logic                      cpu_reset;
   logic                      rd_d                  = 1'b0;
   int                        cyc                   = 0;
   int                        error_cnt             = 0;
   int                        checks                = 0;
   wdr_note_t                 exp_q[$];

   always #20 core_clk = ~core_clk;

   // the pulse resets the rest of the system, as the cpu reset logic would
   assign cpu_reset = wdt_reset;

   wdr_watchdog #(.TPS_W(wdr_pkg::TPS_W)) dut (
      .core_clk              (core_clk),
      .rst                   (rst),
      .cpu_reset             (cpu_reset),
      .sfr_addr              (sfr_addr),
      .sfr_wr                (sfr_wr),
      .sfr_wdata             (sfr_wdata),
      .sfr_rd                (sfr_rd),
      .sfr_rdata             (sfr_rdata),
      .idle                  (idle),
      .power_down            (power_down),
      .system_timer_prescale (system_timer_prescale),
      .wdt_reset             (wdt_reset)
   );

   // ==========================================================
   // monitor: cycle count first, so driver notes line up with it
   always @(posedge core_clk) rd_d <= sfr_rd;

   always @(negedge core_clk) begin : monitor
      wdr_note_t n;
      bit        got;
      cyc = cyc + 1;
      got = (wdt_reset === 1'b1);
      if (got || rd_d) begin
         checks++;
         if (exp_q.size() == 0) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected none", $time, {got, sfr_rdata});
         end else begin
            n = exp_q.pop_front();
            if (n.is_rst !== got || (!got && sfr_rdata !== n.val) ||
                cyc > n.at + n.slack || cyc < n.at - n.slack) begin
               error_cnt++;
               $display("wrong value at %0t: got %h expected %h", $time,
                        {got, sfr_rdata}, {n.is_rst, n.val});
            end
         end
      end
   end

   // ==========================================================
   // bus tasks: strobes stay up between back-to-back requests
   task automatic push(input bit r, input logic [7:0] v, input int dly, input int sl);
      exp_q.push_back('{r, v, cyc + dly, sl});
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit bad = 1'b0);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      sfr_rd    <= 1'b0;
      // taken at the next edge, pulse seen at the falling edge after that
      if (bad) push(1'b1, 8'h00, 2, 0);
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      sfr_wr   <= 1'b0;
      // read data is registered at the taking edge, so two falling edges on
      push(1'b0, v, 2, 0);
      @(posedge core_clk);
   endtask

   task automatic nop(input int n);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask

   task automatic give_verdict;
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic drain(input int lim);
      int i;
      for (i = 0; i < lim && exp_q.size() != 0; i++) @(posedge core_clk);
      if (exp_q.size() != 0) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, 8'h00, 8'h01);
         give_verdict();
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin : main
      int v;
      int n1;
      int n2;
      int i;
      v = $urandom(25604);
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      rd(wdr_pkg::CTRL_ADDR, wdr_pkg::CTRL_RESET);
      rd(wdr_pkg::KEY_ADDR, 8'h00);
      v = $urandom_range(0, 255);
      if (v == 8'ha6 || v == 8'ha7) v = 8'h00;
      rd(v[7:0], 8'h00);
      // flag bits written 1 and bit 0 must not change anything
      for (i = 0; i < 8; i++) begin
         v = $urandom_range(0, 1);
         wr(wdr_pkg::CTRL_ADDR, {i[2:0], v[0], 4'hf});
         rd(wdr_pkg::CTRL_ADDR, {i[2:0], v[0], 4'h0});
      end
      wr(wdr_pkg::CTRL_ADDR, 8'h00);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_SOFT1);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_SOFT2, 1'b1);
      nop(2);
      rd(wdr_pkg::CTRL_ADDR, 8'h04);
      wr(wdr_pkg::CTRL_ADDR, 8'h00);
      rd(wdr_pkg::CTRL_ADDR, 8'h00);
      for (i = 0; i < 4; i++) begin
         v = $urandom_range(0, 255);
         if (v inside {8'h1e, 8'h5a, 8'he1, 8'ha5}) v = 8'h33;
         if (i < 2) begin
            wr(wdr_pkg::KEY_ADDR, v[7:0], 1'b1);
         end else if (i == 2) begin
            wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN1);
            wr(wdr_pkg::KEY_ADDR, v[7:0], 1'b1);
         end else begin
            wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_SOFT1);
            wr(wdr_pkg::CTRL_ADDR, 8'h00, 1'b1);
         end
         nop(2);
         rd(wdr_pkg::CTRL_ADDR, 8'h06);
         wr(wdr_pkg::CTRL_ADDR, 8'h00);
      end
      // prescale of two, freeze in idle, a read between the key bytes
      system_timer_prescale <= {{(wdr_pkg::TPS_W-1){1'b0}}, 1'b1};
      wr(wdr_pkg::CTRL_ADDR, 8'h10);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN1);
      rd(wdr_pkg::CTRL_ADDR, 8'h10);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN2);
      nop(1);
      rd(wdr_pkg::CTRL_ADDR, 8'h11);
      nop(5000);
      n1 = $urandom_range(200, 800);
      n2 = $urandom_range(100, 400);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN1);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN2);
      push(1'b1, 8'h00, 1 + 32768 + n1 + n2, 4);
      nop(100);
      idle <= 1'b1;
      nop(n1);
      idle       <= 1'b0;
      power_down <= 1'b1;
      nop(n2);
      power_down <= 1'b0;
      drain(40000);
      nop(2);
      rd(wdr_pkg::CTRL_ADDR, 8'h12);
      // no prescale, period code 1, idle without freeze keeps counting
      system_timer_prescale <= '0;
      wr(wdr_pkg::CTRL_ADDR, 8'h20);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN1);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN2);
      push(1'b1, 8'h00, 1 + 32768, 2);
      idle <= 1'b1;
      nop(1);
      drain(34000);
      idle <= 1'b0;
      nop(2);
      rd(wdr_pkg::CTRL_ADDR, 8'h22);
      // power-on reset in mid run stops counting and clears the flags
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN1);
      wr(wdr_pkg::KEY_ADDR, wdr_pkg::KEY_RUN2);
      nop(100);
      rst <= 1'b1;
      nop(1);
      rst <= 1'b0;
      nop(1);
      rd(wdr_pkg::CTRL_ADDR, 8'h00);
      nop(20);
      drain(10);
      give_verdict();
   end
endmodule
